//--- logic/rtcc_control.sv
// RTC control: serial register port, interrupt gating, watch gate,
// self-recovery watchdog, square-wave output and drift compensation.
// Assumes i_osc_clock is the free-running 32.768 kHz oscillator and
// the voltage, thermometer and heartbeat inputs come from i_clock logic.
`timescale 1ns/1ps

module rtcc_control #(
  parameter logic [6:0] I2C_ADDR = 7'h56
) (
  input  logic                i_clock,
  input  logic                i_resetn,
  input  logic                i_clock_enable,
  input  logic                i_osc_clock,
  input  logic                i_scl,
  input  logic                i_sda,
  output rtcc_pkg::rtcc_od_t  o_sda,
  output rtcc_pkg::rtcc_od_t  o_int,
  input  logic                i_low_voltage2,
  input  logic                i_recovery_kick,
  input  logic                i_temp_valid,
  input  logic [7:0]          i_temperature,
  input  logic                i_square_wave_gate_pin,
  output logic                o_square_wave_pin,
  output logic [7:0]          o_seconds
);
  rtcc_pkg::rtcc_main_t s;
  rtcc_pkg::rtcc_main_t n;
  rtcc_pkg::rtcc_osc_t  o;
  rtcc_pkg::rtcc_osc_t  n2;
  logic [1:0] osc_rst_q;
  logic       scl;
  logic       sda;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       tick;
  logic       wr;
  logic       ld;
  logic       fire;
  logic       irq;
  logic [5:0] lim;
  logic [7:0] rdat;
  logic       slot;

  function automatic logic [7:0] comp_calc(input logic [7:0] off,
                                           input logic [7:0] coef,
                                           input logic [7:0] t0,
                                           input logic [7:0] tmp);
    logic signed [9:0] d;
    logic [19:0]       sq;
    logic [27:0]       q;
    logic [7:0]        drift;
    logic [7:0]        mag;
    d = signed'({2'b00, tmp}) - signed'({4'h0, t0[5:0]})
        - signed'({2'b00, rtcc_pkg::TEMP_ZERO});
    sq = 20'(d * d);
    q = sq * coef;
    drift = q[rtcc_pkg::DRIFT_SHIFT +: 8];
    mag = {1'b0, off[6:0]};
    // Positive result means pulses to add; a fast crystal subtracts
    return off[7] ? drift - mag : drift + mag;
  endfunction

  // Synchronised bus lines: stage [1] is the usable level, [2] its past
  assign scl   = s.scl_s[1];
  assign sda   = s.sda_s[1];
  assign rise  = scl & ~s.scl_s[2];
  assign fall  = ~scl & s.scl_s[2];
  assign start = scl & s.scl_s[2] & s.sda_s[2] & ~sda;
  assign stop  = scl & s.scl_s[2] & ~s.sda_s[2] & sda;
  assign tick  = s.tick_s[1] & ~s.tick_s[2];
  assign lim   = s.pconf[rtcc_pkg::B_SCAN] ? rtcc_pkg::WD_LONG
                                           : rtcc_pkg::WD_SHORT;
  assign fire  = s.ctrl1[rtcc_pkg::B_RECEN] && (s.wd >= lim);
  assign irq   = (s.int_en[rtcc_pkg::B_LV2]
                  & (s.flags[rtcc_pkg::B_LV2] | s.status[rtcc_pkg::B_LV2]))
               | (s.int_en[rtcc_pkg::B_REC]
                  & (s.flags[rtcc_pkg::B_REC] | s.status[rtcc_pkg::B_REC]));
  assign o_int.out  = 1'b0;
  assign o_int.oe_n = ~irq;
  assign o_sda.out  = 1'b0;
  assign o_sda.oe_n = ~s.drive;
  assign o_seconds  = s.seconds;

  always_comb begin
    case (s.ptr)
      rtcc_pkg::ADDR_CTRL1:   rdat = s.ctrl1;
      rtcc_pkg::ADDR_INT_EN:  rdat = s.int_en;
      rtcc_pkg::ADDR_FLAGS:   rdat = s.flags;
      rtcc_pkg::ADDR_STATUS:  rdat = s.status;
      rtcc_pkg::ADDR_SECONDS: rdat = s.seconds;
      rtcc_pkg::ADDR_TEMP:    rdat = s.temp;
      rtcc_pkg::ADDR_PCONF:   rdat = s.pconf;
      rtcc_pkg::ADDR_XOFF:    rdat = s.xoff;
      rtcc_pkg::ADDR_XCOEF:   rdat = s.xcoef;
      rtcc_pkg::ADDR_XT0:     rdat = s.xt0;
      default:                rdat = 8'h00;
    endcase
  end

  always_comb begin
    n = s;
    wr = 1'b0;
    ld = 1'b0;
    n.scl_s  = {s.scl_s[1:0], i_scl};
    n.sda_s  = {s.sda_s[1:0], i_sda};
    n.tick_s = {s.tick_s[1:0], o.presc[rtcc_pkg::TAP_1]};
    // Serial slave: 7-bit address, pointer byte, then data with auto-increment
    if (start) begin
      n.st = rtcc_pkg::I_ADDR;
      n.cnt = '0;
      n.drive = 1'b0;
    end else if (stop) begin
      n.st = rtcc_pkg::I_IDLE;
      n.drive = 1'b0;
    end else begin
      case (s.st)
        rtcc_pkg::I_IDLE: begin
        end
        rtcc_pkg::I_ADDR, rtcc_pkg::I_RECV: begin
          if (rise) begin
            n.shift = {s.shift[6:0], sda};
            n.cnt = s.cnt + 4'h1;
          end
          if (fall && s.cnt == rtcc_pkg::BITS) begin
            n.cnt = '0;
            if (s.st == rtcc_pkg::I_ADDR) begin
              if (s.shift[7:1] == I2C_ADDR) begin
                n.rw = s.shift[0];
                n.first = 1'b1;
                n.drive = 1'b1;
                n.st = rtcc_pkg::I_AACK;
              end else begin
                n.st = rtcc_pkg::I_IDLE;
              end
            end else begin
              n.drive = 1'b1;
              n.st = rtcc_pkg::I_WACK;
              if (s.first) begin
                n.ptr = s.shift;
                n.first = 1'b0;
              end else begin
                wr = 1'b1;
                n.ptr = s.ptr + 8'h01;
              end
            end
          end
        end
        rtcc_pkg::I_AACK, rtcc_pkg::I_WACK: begin
          if (fall) begin
            n.drive = 1'b0;
            n.st = rtcc_pkg::I_RECV;
            ld = (s.st == rtcc_pkg::I_AACK) && s.rw;
          end
        end
        rtcc_pkg::I_SEND: begin
          if (fall) begin
            if (s.cnt == rtcc_pkg::BITS) begin
              n.drive = 1'b0;
              n.st = rtcc_pkg::I_RACK;
            end else begin
              n.drive = ~s.shift[6];
              n.shift = {s.shift[6:0], 1'b0};
              n.cnt = s.cnt + 4'h1;
            end
          end
        end
        rtcc_pkg::I_RACK: begin
          if (rise && sda) begin
            n.st = rtcc_pkg::I_IDLE;
          end else if (fall) begin
            ld = 1'b1;
          end
        end
        default: n.st = rtcc_pkg::I_IDLE;
      endcase
    end
    if (ld) begin
      n.shift = rdat;
      n.ptr = s.ptr + 8'h01;
      n.drive = ~rdat[7];
      n.cnt = 4'h1;
      n.st = rtcc_pkg::I_SEND;
    end
    // Host writes
    if (wr) begin
      case (s.ptr)
        rtcc_pkg::ADDR_CTRL1:   n.ctrl1 = s.shift;
        rtcc_pkg::ADDR_INT_EN:  n.int_en = s.shift & rtcc_pkg::INT_MASK;
        rtcc_pkg::ADDR_FLAGS:   n.flags = s.flags & s.shift;
        rtcc_pkg::ADDR_STATUS:  n.status = s.status & s.shift;
        rtcc_pkg::ADDR_SECONDS: n.seconds = s.shift;
        rtcc_pkg::ADDR_TEMP:    n.temp = s.shift;
        rtcc_pkg::ADDR_PCONF:   n.pconf = s.shift;
        rtcc_pkg::ADDR_XOFF:    n.xoff = s.shift;
        rtcc_pkg::ADDR_XCOEF:   n.xcoef = s.shift;
        rtcc_pkg::ADDR_XT0:     n.xt0 = s.shift & rtcc_pkg::T0_MASK;
        default: begin
        end
      endcase
    end
    // Hardware sets come after the host clear, so a set in the same cycle wins
    if (i_low_voltage2) begin
      n.status[rtcc_pkg::B_LV2] = 1'b1;
      if (s.int_en[rtcc_pkg::B_LV2]) begin
        n.flags[rtcc_pkg::B_LV2] = 1'b1;
      end
    end
    if (i_temp_valid) begin
      n.temp = i_temperature;
    end
    // Watch counter steps only while running and not being written
    if (tick && s.ctrl1[rtcc_pkg::B_RUN]
        && !(wr && s.ptr == rtcc_pkg::ADDR_SECONDS)) begin
      n.seconds = (s.seconds >= rtcc_pkg::SEC_MAX) ? 8'h00 : s.seconds + 8'h01;
    end
    // Compensation value refreshed once per 32-second period
    if (tick) begin
      n.sec32 = s.sec32 + 5'h01;
      if (s.sec32 == rtcc_pkg::COMP_LAST) begin
        n.comp = comp_calc(s.xoff, s.xcoef, s.xt0, s.temp);
        n.comp_tgl = ~s.comp_tgl;
      end
    end
    // Self-recovery watchdog
    if (!s.ctrl1[rtcc_pkg::B_RECEN] || i_recovery_kick) begin
      n.wd = '0;
    end else if (tick) begin
      n.wd = s.wd + 6'h01;
    end
    if (fire) begin
      n.ctrl1 = rtcc_pkg::CTRL1_RST;
      n.int_en = '0;
      n.flags = rtcc_pkg::FLAG_REC;
      n.status = rtcc_pkg::FLAG_REC;
      n.wd = '0;
      n.st = rtcc_pkg::I_IDLE;
      n.drive = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
      // Bus synchronisers start at the idle high level, so no false edge on release
      s.scl_s <= '1;
      s.sda_s <= '1;
      s.ctrl1 <= rtcc_pkg::CTRL1_RST;
      s.pconf <= rtcc_pkg::PCONF_RST;
      s.xt0 <= rtcc_pkg::XT0_RST;
      s.temp <= rtcc_pkg::TEMP_RST;
    end else if (i_clock_enable) begin
      s <= n;
    end
  end

  // Oscillator domain: own reset release, prescaler, pulse adjust, output
  always_ff @(posedge i_osc_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      osc_rst_q <= 2'b00;
    end else begin
      osc_rst_q <= {osc_rst_q[0], 1'b1};
    end
  end

  assign slot = o.presc[rtcc_pkg::TAP_32-1:0] == rtcc_pkg::ADJ_SLOT;

  always_comb begin
    n2 = o;
    n2.tgl_s = {o.tgl_s[1:0], s.comp_tgl};
    n2.cfg0 = {s.ctrl1[rtcc_pkg::B_PINF], s.pconf[rtcc_pkg::B_FSEL+1:rtcc_pkg::B_FSEL],
               i_square_wave_gate_pin};
    n2.cfg1 = o.cfg0;
    n2.held = 1'b0;
    n2.presc = o.presc + 15'h0001;
    if (slot && !o.held && o.adj != 8'h00) begin
      if (o.adj[7]) begin
        n2.presc = o.presc;
        n2.held = 1'b1;
        n2.adj = o.adj + 8'h01;
      end else begin
        n2.presc = o.presc + 15'h0002;
        n2.adj = o.adj - 8'h01;
      end
    end
    // Value is stable for a whole period once the toggle is seen
    if (o.tgl_s[2] ^ o.tgl_s[1]) begin
      n2.adj = s.comp;
    end
    case (o.cfg1[2:1])
      rtcc_pkg::FSEL_1K: n2.sq = o.presc[rtcc_pkg::TAP_1K];
      rtcc_pkg::FSEL_32: n2.sq = o.presc[rtcc_pkg::TAP_32];
      default:           n2.sq = o.presc[rtcc_pkg::TAP_1];
    endcase
  end

  always_ff @(posedge i_osc_clock or negedge osc_rst_q[1]) begin
    if (!osc_rst_q[1]) begin
      o <= '0;
    end else begin
      o <= n2;
    end
  end

  // Raw selection passes the oscillator itself; watch-run is not involved
  assign o_square_wave_pin = o.cfg1[3] & o.cfg1[0]
                           & ((o.cfg1[2:1] == rtcc_pkg::FSEL_RAW) ? i_osc_clock : o.sq);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  sequence s_lv2_drop;
    s.status[rtcc_pkg::B_LV2] ##1 !s.status[rtcc_pkg::B_LV2];
  endsequence

  property p_lv2_int;
    s.int_en[rtcc_pkg::B_LV2] && s.flags[rtcc_pkg::B_LV2] |-> !o_int.oe_n;
  endproperty
  a_lv2_int: assert property (p_lv2_int) else $error("lv2 flag not on int");

  property p_rec_int;
    s.int_en[rtcc_pkg::B_REC] && s.flags[rtcc_pkg::B_REC] |-> !o_int.oe_n;
  endproperty
  a_rec_int: assert property (p_rec_int) else $error("rec flag not on int");

  // Status bit only drops through a host write of 0 or a recovery reset
  property p_int_release;
    s_lv2_drop |-> $past(fire) || ($past(wr) && $past(s.ptr) == rtcc_pkg::ADDR_STATUS
                                   && !$past(s.shift[rtcc_pkg::B_LV2]));
  endproperty
  a_int_release: assert property (p_int_release) else $error("int freed early");

  property p_run_hold;
    i_clock_enable && !s.ctrl1[rtcc_pkg::B_RUN] && !wr |=> $stable(s.seconds);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("time moved while stopped");

  property p_run_count;
    i_clock_enable && tick && s.ctrl1[rtcc_pkg::B_RUN] && !wr
      |=> s.seconds != $past(s.seconds);
  endproperty
  a_run_count: assert property (p_run_count) else $error("tick not counted");

  property p_wd_bound;
    s.wd <= rtcc_pkg::WD_LONG;
  endproperty
  a_wd_bound: assert property (p_wd_bound) else $error("watchdog overran");

  property p_fire_flags;
    i_clock_enable && fire |=> s.flags[rtcc_pkg::B_REC] && s.status[rtcc_pkg::B_REC]
                               && s.ctrl1 == rtcc_pkg::CTRL1_RST;
  endproperty
  a_fire_flags: assert property (p_fire_flags) else $error("recovery not flagged");

  property p_flag_keep;
    i_clock_enable && wr && s.ptr == rtcc_pkg::ADDR_FLAGS && s.shift[rtcc_pkg::B_REC]
      && s.flags[rtcc_pkg::B_REC] |=> s.flags[rtcc_pkg::B_REC];
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("write 1 cleared flag");

  property p_clk_1k;
    @(posedge i_osc_clock) disable iff (!osc_rst_q[1])
      o.cfg1 == {1'b1, rtcc_pkg::FSEL_1K, 1'b1} && $stable(o.cfg1) && o.cfg0 == o.cfg1
      |=> o_square_wave_pin == $past(o.presc[rtcc_pkg::TAP_1K]);
  endproperty
  a_clk_1k: assert property (p_clk_1k) else $error("1024 Hz tap wrong");
endmodule

//--- logic/rtcc_pkg.sv
// Shared constants and types for the RTC control block.
// Assumes one system clock domain plus the 32.768 kHz oscillator domain.
package rtcc_pkg;
  // Register offsets on the serial register port
  localparam logic [7:0] ADDR_CTRL1   = 8'h00;
  localparam logic [7:0] ADDR_INT_EN  = 8'h01;
  localparam logic [7:0] ADDR_FLAGS   = 8'h02;
  localparam logic [7:0] ADDR_STATUS  = 8'h03;
  localparam logic [7:0] ADDR_SECONDS = 8'h08;
  localparam logic [7:0] ADDR_TEMP    = 8'h20;
  localparam logic [7:0] ADDR_PCONF   = 8'h30;
  localparam logic [7:0] ADDR_XOFF    = 8'h31;
  localparam logic [7:0] ADDR_XCOEF   = 8'h32;
  localparam logic [7:0] ADDR_XT0     = 8'h33;
  // Field positions
  localparam int B_RUN   = 0;
  localparam int B_RECEN = 4;
  localparam int B_PINF  = 7;
  localparam int B_LV2   = 3;
  localparam int B_REC   = 4;
  localparam int B_SCAN  = 0;
  localparam int B_FSEL  = 2;
  // Reset values and masks
  localparam logic [7:0] CTRL1_RST = 8'h11;
  localparam logic [7:0] PCONF_RST = 8'h00;
  localparam logic [7:0] XT0_RST   = 8'h19;
  localparam logic [7:0] TEMP_RST  = 8'h55;
  localparam logic [7:0] FLAG_REC  = 8'h10;
  localparam logic [7:0] INT_MASK  = 8'h1f;
  localparam logic [7:0] T0_MASK   = 8'h3f;
  localparam logic [7:0] SEC_MAX   = 8'h3b;
  localparam logic [7:0] TEMP_ZERO = 8'h3c;
  // Timing: scan intervals in seconds, watchdog spans two of them
  localparam logic [5:0] SCAN_SHORT_S = 6'h01;
  localparam logic [5:0] SCAN_LONG_S  = 6'h10;
  localparam logic [5:0] WD_SHORT = 6'(2 * SCAN_SHORT_S);
  localparam logic [5:0] WD_LONG  = 6'(2 * SCAN_LONG_S);
  localparam logic [4:0] COMP_LAST = 5'h1f;
  localparam int PRESC_W = 15;
  localparam int TAP_1K = 4;
  localparam int TAP_32 = 9;
  localparam int TAP_1  = 14;
  localparam logic [8:0] ADJ_SLOT = 9'h001;
  localparam int DRIFT_SHIFT = 18;
  localparam logic [3:0] BITS = 4'h8;
  localparam logic [1:0] FSEL_RAW = 2'b00;
  localparam logic [1:0] FSEL_1K  = 2'b01;
  localparam logic [1:0] FSEL_32  = 2'b10;

  typedef enum logic [3:0] {
    I_IDLE = 4'h0, I_ADDR = 4'h1, I_AACK = 4'h2, I_RECV = 4'h3,
    I_WACK = 4'h4, I_SEND = 4'h5, I_RACK = 4'h6
  } rtcc_i2c_t;

  // Open-drain pin drive: out level and active-low enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } rtcc_od_t;

  typedef struct packed {
    rtcc_i2c_t  st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic       rw;
    logic       first;
    logic       drive;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] tick_s;
    logic [7:0] ctrl1;
    logic [7:0] int_en;
    logic [7:0] flags;
    logic [7:0] status;
    logic [7:0] pconf;
    logic [7:0] xoff;
    logic [7:0] xcoef;
    logic [7:0] xt0;
    logic [7:0] temp;
    logic [7:0] seconds;
    logic [5:0] wd;
    logic [4:0] sec32;
    logic [7:0] comp;
    logic       comp_tgl;
  } rtcc_main_t;

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic [7:0]         adj;
    logic               held;
    logic [2:0]         tgl_s;
    logic [3:0]         cfg0;
    logic [3:0]         cfg1;
    logic               sq;
  } rtcc_osc_t;
endpackage

//--- tb/rtc_control_square_wave_pin_recovery_tb_top.sv
// Bench for the RTC control block: register rows, interrupts, watch gate,
// square-wave output and the recovery watchdog.
// Assumes a 125 MHz system clock and a fast 6 ns oscillator clock.
`timescale 1ns/1ps
module rtc_control_square_wave_pin_recovery_tb_top;
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } rtcc_row_t;

  logic               i_clock = 1'b0;
  logic               i_osc_clock = 1'b0;
  logic               i_resetn = 1'b0;
  logic               i_low_voltage2 = 1'b0;
  logic               i_recovery_kick = 1'b1;
  logic               i_temp_valid = 1'b0;
  logic [7:0]         i_temperature = 8'h00;
  logic               i_square_wave_gate_pin = 1'b1;
  logic               i_clock_enable = 1'b1;
  logic               scl;
  logic               host_sda_oe_n;
  logic               sda_line;
  rtcc_pkg::rtcc_od_t dev_sda;
  rtcc_pkg::rtcc_od_t dev_int;
  logic               o_square_wave_pin;
  logic [7:0]         o_seconds;
  int                 error_cnt = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  logic [7:0]         got;
  time                hi;
  time                per;
  rtcc_row_t          rows [13] = '{
    '{1'b0, 8'h00, 8'h00, 8'h11},  // Reset values
    '{1'b0, 8'h01, 8'h00, 8'h00},
    '{1'b0, 8'h02, 8'h00, 8'h00},
    '{1'b0, 8'h03, 8'h00, 8'h00},
    '{1'b0, 8'h30, 8'h00, 8'h00},
    '{1'b0, 8'h20, 8'h00, 8'h55},
    '{1'b0, 8'h33, 8'h00, 8'h19},
    '{1'b1, 8'h01, 8'hff, 8'h1f},  // Unused enable bits read 0
    '{1'b1, 8'h01, 8'h00, 8'h00},
    '{1'b1, 8'h10, 8'haa, 8'h00},  // Unmapped place
    '{1'b1, 8'h02, 8'hff, 8'h00},  // Ones never set a flag
    '{1'b1, 8'h30, 8'h04, 8'h04},
    '{1'b1, 8'h33, 8'hff, 8'h3f}
  };
  time                half_t [3] = '{96, 3072, 3};
  logic [7:0]         fsel [3] = '{8'h04, 8'h08, 8'h00};

  // Released data line floats high through the pull-up
  assign sda_line = host_sda_oe_n & dev_sda.oe_n;

  always #4 i_clock = ~i_clock;
  initial begin
    #1.7;
    forever #3 i_osc_clock = ~i_osc_clock;
  end

  rtcc_control rtcc_control_i (
    .i_clock                (i_clock),
    .i_resetn               (i_resetn),
    .i_clock_enable         (i_clock_enable),
    .i_osc_clock            (i_osc_clock),
    .i_scl                  (scl),
    .i_sda                  (sda_line),
    .o_sda                  (dev_sda),
    .o_int                  (dev_int),
    .i_low_voltage2         (i_low_voltage2),
    .i_recovery_kick        (i_recovery_kick),
    .i_temp_valid           (i_temp_valid),
    .i_temperature          (i_temperature),
    .i_square_wave_gate_pin (i_square_wave_gate_pin),
    .o_square_wave_pin      (o_square_wave_pin),
    .o_seconds              (o_seconds)
  );

  rtcc_host_model rtcc_host_model_i (
    .i_clock    (i_clock),
    .i_sda      (sda_line),
    .o_scl      (scl),
    .o_sda_oe_n (host_sda_oe_n)
  );

  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_pin(input logic g, input logic e);
    cmp_val({7'h00, g}, {7'h00, e});
  endtask

  task automatic cmp_time(input time g, input time e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rtcc_host_model_i.write_reg(a, d);
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    rtcc_host_model_i.read_reg(a, q);
    cmp_val(q, e);
  endtask

  task automatic measure(output time h, output time p);
    time t0;
    @(posedge o_square_wave_pin);
    t0 = $time;
    @(negedge o_square_wave_pin);
    h = $time - t0;
    @(posedge o_square_wave_pin);
    p = $time - t0;
  endtask

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(negedge i_clock);
    cmp_pin(dev_int.oe_n, 1'b1);
    i_resetn = 1'b1;
    repeat (4) @(negedge i_clock);
    foreach (rows[r]) begin
      if (rows[r].w) wr(rows[r].a, rows[r].d);
      check_reg(rows[r].a, rows[r].e);
    end
    i_temperature = 8'h3c;
    i_temp_valid  = 1'b1;
    @(negedge i_clock);
    i_temp_valid = 1'b0;
    check_reg(8'h20, 8'h3c);
    wr(8'h01, 8'h08);
    i_low_voltage2 = 1'b1;
    @(negedge i_clock);
    i_low_voltage2 = 1'b0;
    repeat (2) @(negedge i_clock);
    cmp_pin(dev_int.oe_n, 1'b0);
    cmp_pin(dev_int.out, 1'b0);
    check_reg(8'h02, 8'h08);
    check_reg(8'h03, 8'h08);
    wr(8'h02, 8'h00);
    cmp_pin(dev_int.oe_n, 1'b0);
    wr(8'h03, 8'h08);
    check_reg(8'h03, 8'h08);
    wr(8'h03, 8'h00);
    repeat (2) @(negedge i_clock);
    cmp_pin(dev_int.oe_n, 1'b1);
    // A low-voltage pulse while the enable is low must leave no trace
    i_clock_enable = 1'b0;
    i_low_voltage2 = 1'b1;
    @(negedge i_clock);
    i_low_voltage2 = 1'b0;
    @(negedge i_clock);
    i_clock_enable = 1'b1;
    repeat (2) @(negedge i_clock);
    cmp_pin(dev_int.oe_n, 1'b1);
    check_reg(8'h03, 8'h00);
    for (int n = 0; n < 30000 && o_seconds !== 8'h01; n++) @(negedge i_clock);
    cmp_val(o_seconds, 8'h01);
    // Stop the watch, preset time, make the pin a clock and stop kicking
    wr(8'h00, 8'h90);
    wr(8'h08, 8'h05);
    i_recovery_kick = 1'b0;
    foreach (fsel[k]) begin
      wr(8'h30, fsel[k]);
      measure(hi, per);
      measure(hi, per);
      cmp_time(per, 2 * half_t[k]);
      if (k < 2) cmp_time(hi, half_t[k]);
      if (k == 0) begin
        @(negedge i_clock);
        i_square_wave_gate_pin = 1'b0;
        repeat (10) @(negedge i_clock);
        for (int s = 0; s < 8; s++) begin
          repeat (5) @(negedge i_clock);
          cmp_pin(o_square_wave_pin, 1'b0);
        end
        i_square_wave_gate_pin = 1'b1;
      end
    end
    wr(8'h30, 8'h08);
    got = 8'h00;
    for (int n = 0; n < 100 && got !== 8'h11; n++) rtcc_host_model_i.read_reg(8'h00, got);
    cmp_val(got, 8'h11);
    cmp_val(o_seconds, 8'h05);
    cmp_pin(o_square_wave_pin, 1'b0);
    check_reg(8'h02, 8'h10);
    check_reg(8'h03, 8'h10);
    check_reg(8'h01, 8'h00);
    check_reg(8'h30, 8'h08);
    wr(8'h01, 8'h10);
    cmp_pin(dev_int.oe_n, 1'b0);
    wr(8'h02, 8'h00);
    cmp_pin(dev_int.oe_n, 1'b0);
    wr(8'h03, 8'h00);
    repeat (2) @(negedge i_clock);
    cmp_pin(dev_int.oe_n, 1'b1);
    // Second reset in mid-run: control returns to its power-up values
    @(negedge i_clock);
    i_resetn = 1'b0;
    repeat (2) @(negedge i_clock);
    cmp_val(o_seconds, 8'h00);
    cmp_pin(o_square_wave_pin, 1'b0);
    cmp_pin(dev_int.oe_n, 1'b1);
    i_resetn = 1'b1;
    repeat (4) @(negedge i_clock);
    check_reg(8'h00, 8'h11);
    final_report();
  end
endmodule

//--- tb/rtcc_host_model.sv
// Host model: serial register master for the RTC control block.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module rtcc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h56,
  parameter int         HALF     = 8
) (
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe_n
);
  initial begin
    o_scl      = 1'b1;
    o_sda_oe_n = 1'b1;
  end

  task automatic gap();
    repeat (HALF) @(negedge i_clock);
  endtask

  // Data moves one cycle after the clock falls so no edge is seen as a frame mark
  task automatic put_bit(input logic b, output logic r);
    @(negedge i_clock);
    o_sda_oe_n = b;
    gap();
    o_scl = 1'b1;
    gap();
    r = i_sda;
    o_scl = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d, input logic last, output logic [7:0] q,
                          output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
    put_bit(last, ack);
  endtask

  // Serves for a first and a repeated start
  task automatic start();
    @(negedge i_clock);
    o_sda_oe_n = 1'b1;
    gap();
    o_scl = 1'b1;
    gap();
    o_sda_oe_n = 1'b0;
    gap();
    o_scl = 1'b0;
  endtask

  task automatic stop();
    @(negedge i_clock);
    o_sda_oe_n = 1'b0;
    gap();
    o_scl = 1'b1;
    gap();
    o_sda_oe_n = 1'b1;
    gap();
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start();
    put_byte({DEV_ADDR, 1'b0}, 1'b1, q, k);
    put_byte(a, 1'b1, q, k);
    put_byte(d, 1'b1, q, k);
    stop();
  endtask

  // One byte, ended by a not-acknowledge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start();
    put_byte({DEV_ADDR, 1'b0}, 1'b1, q, k);
    put_byte(a, 1'b1, q, k);
    start();
    put_byte({DEV_ADDR, 1'b1}, 1'b1, q, k);
    put_byte(8'hff, 1'b1, d, k);
    stop();
  endtask
endmodule
